//--- elmc_assertions.sv
// Port assertions for the event-log mission controller
`timescale 1ns/100ps
module elmc_assertions (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Host register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  // Timekeeping and event pin
  input wire logic        etc_tick,
  input wire logic [63:0] time_date,
  input wire logic        event_in,
  // Status
  input wire logic        mission_active,
  input wire logic        mission_armed
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_clear;
    reg_wr && reg_addr == 8'h0E && reg_wdata[6] && !reg_wdata[7] ##1 !reg_wr
    ##1 reg_wr && reg_addr == 8'h0F && reg_wdata[4] && !reg_wdata[5];
  endsequence
  sequence s_start;
    reg_wr && reg_addr == 8'h0F && reg_wdata[5];
  endsequence
  sequence s_clear_legal;
    reg_wdata[2:1] != 2'b00 ##0 s_clear;
  endsequence
  sequence s_clear_none;
    reg_wdata[2:1] == 2'b00 ##0 s_clear;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero without read");
  a_active_mask: assert property (mission_active && !$past(reg_wr) && reg_rd && reg_addr >= 8'h30
    |=> reg_rdata == 8'h00) else $error("upper register visible during mission");
  a_stop_write: assert property (mission_active && reg_wr |-> ##2 (!mission_active && !mission_armed))
    else $error("write did not stop mission");
  a_trig_none: assert property (reg_wr && reg_addr == 8'h0E && reg_wdata[2:1] == 2'b00 ##1 !reg_wr
    |=> !mission_armed && !mission_active) else $error("mission with no trigger select");
  a_start_now: assert property (s_clear_legal ##1 !reg_wr ##1 s_start |-> ##2 (mission_active && mission_armed))
    else $error("immediate start failed");
  a_start_refused: assert property (s_clear_none ##1 !reg_wr ##1 s_start |-> ##2 !mission_active)
    else $error("start accepted with no trigger select");
  a_clear_zero: assert property (s_clear ##1 !reg_wr ##1 (reg_rd && reg_addr >= 8'h38 && reg_addr <= 8'h40)
    |=> reg_rdata == 8'h00) else $error("state not zero after clear");
  a_active_armed: assert property (mission_active |-> mission_armed)
    else $error("active without arm bit");
  a_stop_arm: assert property ($fell(mission_active) |-> !mission_armed)
    else $error("arm bit kept after stop");
endmodule // elmc_assertions

bind elmc_event_log_mission_control elmc_assertions i_chk (.clock(clock), .reset_n(reset_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .etc_tick(etc_tick),
  .time_date(time_date), .event_in(event_in), .mission_active(mission_active), .mission_armed(mission_armed));

//--- elmc_edge_detect.sv
// Synchroniser and edge detector for the event input
`timescale 1ns/100ps
module elmc_edge_detect (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Raw input
  input  wire logic sig_in,
  // Edge pulses
  output logic      rise,
  output logic      fall
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // Two-stage synchroniser, then compare consecutive samples
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= sig_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;
endmodule // elmc_edge_detect

//--- elmc_event_log_mission_control.sv
// Event-log mission controller: trigger, mission start/stop, log memory and rollover
//
// Summary of operation
// - Trigger select 01 falling edge, 10 rising edge, 11 both edges.
// - Trigger select 00: events ignored and no mission may start.
// - Each event during a mission logs the elapsed counter value while the log is not full or wraparound is enabled.
// - Host writes log address low byte at 41h, high byte at 42h.
// - Log byte at the selected log address reads at 43h.
// - Log spans 0000h-07FFh, 1024 two-byte durations; address advances per record.
// - Armed: first event sets active, stamps, zeroes rollover stamp, counts, starts counter.
// - Arm bit write of one accepted only when log is cleared.
// - Writing active flag one arms, stamps, zeroes rollover stamp, counts, starts counter.
// - After immediate start, first event logs time since start, then since previous.
// - Active flag write of one accepted only while log is cleared.
// - Cleared flag means all log state zero; stopped missions need clearing first.
// - Control bit 3 enables wraparound, overwriting from a new start stamp.
// - Wrap at 1024 records: new stamp, rollover stamp gets time, overwrite first slot.
// - Any wraparound sets the wrap flag.
// - Without wraparound logging stops after event 1025; pointer wraps 07FEh to 0000h.
// - With log full and no wraparound, events keep being counted.
// - Event counter holds all events of the mission, including unlogged ones.
// - Address pointer points at the next byte to write, which is the oldest logged data once the log is full.
// - Host cannot write the log memory.
// - Arm bit clears whenever a mission stops.
// - Counter reaching FFFFh wraps, event count unchanged; logs FFFFh and advances pointer only while log not full.
// - Any host write during a mission stops it and clears the active flag.
`timescale 1ns/100ps
module elmc_event_log_mission_control #(
  // Log geometry
  parameter int LOG_BYTES   = elmc_pkg::LOG_BYTES,
  parameter int LOG_RECORDS = elmc_pkg::LOG_RECORDS,
  parameter int LOG_ABITS   = elmc_pkg::LOG_ABITS
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Host register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Timekeeping base
  input  wire logic        etc_tick,
  input  wire logic [63:0] time_date,
  // Event pin
  input  wire logic        event_in,
  // Status outputs
  output logic             mission_active,
  output logic             mission_armed
);
  localparam int LB = LOG_BYTES;
  localparam int LR = LOG_RECORDS;
  localparam int AW = LOG_ABITS;

  // Pointer, byte-wide address registers and record count must agree on one geometry
  if (AW < 9 || AW > 16 || LB != (1 << AW) || LR * 2 != LB) begin : g_bad_geometry
    $error("Unsupported log geometry");
  end

  // Trigger decode used for both event selection and start qualification
  function automatic logic trig_hit(input logic [1:0] sel, input logic rise, input logic fall);
    trig_hit = (sel[0] & fall) | (sel[1] & rise);
  endfunction

  // State
  logic [7:0]    ctl_reg;
  logic          active_reg;
  logic          cleared_reg;
  logic          wrap_flag_reg;
  logic          clr_armed_reg;
  logic [63:0]   stamp_reg;
  logic [15:0]   roll_stamp_reg;
  logic [23:0]   evcnt_reg;
  logic [15:0]   etc_reg;
  logic [AW-1:0] ptr_reg;
  logic [AW-1:0] stored_reg;
  logic [7:0]    log_addr_low_reg;
  logic [7:0]    log_addr_high_reg;
  logic [7:0]    log_mem [LB];

  // Combinational control
  logic          ev_rise;
  logic          ev_fall;
  logic [1:0]    trig_sel;
  logic          trig_ok;
  logic          event_hit;
  logic          wr_ctl;
  logic          wr_sts;
  logic          start_imm;
  logic          start_del;
  logic          start_now;
  logic          stop_now;
  logic          do_clear;
  logic          log_event;
  logic          etc_roll;
  logic          log_full;
  logic          wrap_now;
  logic          store_now;
  logic [15:0]   store_val;
  logic [AW-1:0] log_sel;

  elmc_edge_detect u_edge (
    .clock   (clock),
    .reset_n (reset_n),
    .sig_in  (event_in),
    .rise    (ev_rise),
    .fall    (ev_fall)
  );

  assign trig_sel  = {ctl_reg[elmc_pkg::CTL_TRIG_HIGH], ctl_reg[elmc_pkg::CTL_TRIG_LOW]};
  assign trig_ok   = (trig_sel != elmc_pkg::TRIG_NONE);
  assign event_hit = trig_hit(trig_sel, ev_rise, ev_fall);
  assign wr_ctl    = reg_wr && (reg_addr == elmc_pkg::ADDR_CONTROL);
  assign wr_sts    = reg_wr && (reg_addr == elmc_pkg::ADDR_STATUS);

  // Immediate start by writing the active flag
  assign start_imm = wr_sts && reg_wdata[elmc_pkg::STS_ACTIVE] && cleared_reg && trig_ok && !active_reg;
  // Delayed start on first event after arming
  // An event that meets a host write is dropped, since the write would stop the mission at once
  assign start_del = ctl_reg[elmc_pkg::CTL_ARM] && !active_reg && cleared_reg && event_hit && !reg_wr;
  assign start_now = start_imm || start_del;
  // Any other host write during a mission stops it
  assign stop_now  = reg_wr && active_reg && !start_imm;
  assign do_clear  = wr_sts && reg_wdata[elmc_pkg::STS_CLEAR_CMD] && clr_armed_reg && !active_reg;

  assign log_event = active_reg && event_hit && !stop_now;
  // Counter rollover without an event stores FFFFh as a partial duration while the log is not full
  assign etc_roll  = active_reg && etc_tick && (etc_reg == elmc_pkg::ETC_MAX) && !stop_now && !log_event;
  assign log_full  = (stored_reg == AW'(LR));
  assign wrap_now  = log_event && log_full && ctl_reg[elmc_pkg::CTL_WRAP_EN];
  assign store_now = (log_event && (!log_full || ctl_reg[elmc_pkg::CTL_WRAP_EN])) ||
                     (etc_roll && !log_full);
  assign store_val = log_event ? etc_reg : elmc_pkg::ETC_MAX;
  assign log_sel   = {log_addr_high_reg[AW-9:0], log_addr_low_reg};

  // Control register, arm bit and clear-enable handshake
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctl_reg       <= elmc_pkg::CTL_RESET;
      clr_armed_reg <= 1'b0;
    end else begin
      if (wr_ctl) begin
        ctl_reg <= reg_wdata;
        // Arm only from a cleared log with a legal trigger in the written value
        ctl_reg[elmc_pkg::CTL_ARM] <= reg_wdata[elmc_pkg::CTL_ARM] && cleared_reg && !active_reg &&
                                      ({reg_wdata[elmc_pkg::CTL_TRIG_HIGH], reg_wdata[elmc_pkg::CTL_TRIG_LOW]} !=
                                       elmc_pkg::TRIG_NONE);
        // Clear enable reads back only while the clear command may still follow
        ctl_reg[elmc_pkg::CTL_CLR_EN] <= reg_wdata[elmc_pkg::CTL_CLR_EN] && !reg_wdata[elmc_pkg::CTL_ARM];
      end else if (reg_wr) begin
        ctl_reg[elmc_pkg::CTL_CLR_EN] <= 1'b0;
      end
      if (start_imm) begin
        ctl_reg[elmc_pkg::CTL_ARM] <= 1'b1;
      end else if (stop_now) begin
        ctl_reg[elmc_pkg::CTL_ARM] <= 1'b0;
      end
      if (wr_ctl) begin
        clr_armed_reg <= reg_wdata[elmc_pkg::CTL_CLR_EN] && !reg_wdata[elmc_pkg::CTL_ARM];
      end else if (reg_wr) begin
        clr_armed_reg <= 1'b0;
      end
    end
  end

  // Mission state flags
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      active_reg    <= 1'b0;
      cleared_reg   <= 1'b0;
      wrap_flag_reg <= 1'b0;
    end else begin
      if (start_now) begin
        active_reg  <= 1'b1;
        cleared_reg <= 1'b0;
      end else if (stop_now) begin
        active_reg  <= 1'b0;
      end else if (do_clear) begin
        cleared_reg   <= 1'b1;
        wrap_flag_reg <= 1'b0;
      end
      if (wrap_now) begin
        wrap_flag_reg <= 1'b1;
      end
    end
  end

  // Stamps, event counter, elapsed counter and pointer
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stamp_reg      <= '0;
      roll_stamp_reg <= elmc_pkg::ETC_ZERO;
      evcnt_reg      <= '0;
      etc_reg        <= elmc_pkg::ETC_ZERO;
      ptr_reg        <= '0;
      stored_reg     <= '0;
    end else if (do_clear) begin
      stamp_reg      <= '0;
      roll_stamp_reg <= elmc_pkg::ETC_ZERO;
      evcnt_reg      <= '0;
      etc_reg        <= elmc_pkg::ETC_ZERO;
      ptr_reg        <= '0;
      stored_reg     <= '0;
    end else if (start_now) begin
      stamp_reg      <= time_date;
      roll_stamp_reg <= elmc_pkg::ETC_ZERO;
      evcnt_reg      <= evcnt_reg + elmc_pkg::EVCNT_ONE;
      etc_reg        <= elmc_pkg::ETC_ZERO;
    end else if (log_event) begin
      evcnt_reg <= evcnt_reg + elmc_pkg::EVCNT_ONE;
      etc_reg   <= elmc_pkg::ETC_ZERO;
      // Wrap event: the counter value goes to the rollover stamp and to the first slot
      if (wrap_now) begin
        stamp_reg      <= time_date;
        roll_stamp_reg <= etc_reg;
        stored_reg     <= AW'(1);
      end else if (!log_full) begin
        stored_reg <= stored_reg + AW'(1);
      end
      // Pointer is the next byte to write, which is the oldest record once the log is full
      if (store_now) begin
        ptr_reg <= ptr_reg + AW'(2);
      end
    end else if (active_reg && etc_tick) begin
      etc_reg <= etc_reg + 16'h0001;
      if (store_now) begin
        ptr_reg    <= ptr_reg + AW'(2);
        stored_reg <= stored_reg + AW'(1);
      end
    end
  end

  // Log memory: written only by the mission, cleared as a whole
  always_ff @(posedge clock) begin
    if (!reset_n || do_clear) begin
      for (int i = 0; i < LB; i++) begin
        log_mem[i] <= elmc_pkg::BYTE_ZERO;
      end
    end else if (store_now) begin
      log_mem[ptr_reg]         <= store_val[7:0];
      log_mem[ptr_reg | AW'(1)] <= store_val[15:8];
    end
  end

  // Log address bytes
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      log_addr_low_reg  <= elmc_pkg::BYTE_ZERO;
      log_addr_high_reg <= elmc_pkg::BYTE_ZERO;
    end else begin
      if (reg_wr && reg_addr == elmc_pkg::ADDR_LOG_ADDR_LOW) begin
        log_addr_low_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == elmc_pkg::ADDR_LOG_ADDR_HIGH) begin
        log_addr_high_reg <= reg_wdata;
      end
    end
  end

  // Registered read data; upper map reads zero during a mission
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata <= elmc_pkg::BYTE_ZERO;
    end else if (!reg_rd || (active_reg && reg_addr >= elmc_pkg::ADDR_LOCK_FIRST)) begin
      reg_rdata <= elmc_pkg::BYTE_ZERO;
    end else if (reg_addr >= elmc_pkg::ADDR_STAMP_FIRST && reg_addr <= elmc_pkg::ADDR_STAMP_LAST) begin
      reg_rdata <= stamp_reg[8 * (reg_addr[2:0]) +: 8];
    end else begin
      unique case (reg_addr)
        elmc_pkg::ADDR_CONTROL:       reg_rdata <= ctl_reg;
        elmc_pkg::ADDR_STATUS:        reg_rdata <= {1'b0, cleared_reg, active_reg, 2'b00, wrap_flag_reg, 2'b00};
        elmc_pkg::ADDR_ROLL_LOW:      reg_rdata <= roll_stamp_reg[7:0];
        elmc_pkg::ADDR_ROLL_HIGH:     reg_rdata <= roll_stamp_reg[15:8];
        elmc_pkg::ADDR_EVCNT_LOW:     reg_rdata <= evcnt_reg[7:0];
        elmc_pkg::ADDR_EVCNT_MID:     reg_rdata <= evcnt_reg[15:8];
        elmc_pkg::ADDR_EVCNT_HIGH:    reg_rdata <= evcnt_reg[23:16];
        elmc_pkg::ADDR_ETC_LOW:       reg_rdata <= etc_reg[7:0];
        elmc_pkg::ADDR_ETC_HIGH:      reg_rdata <= etc_reg[15:8];
        elmc_pkg::ADDR_PTR_LOW:       reg_rdata <= ptr_reg[7:0];
        elmc_pkg::ADDR_PTR_HIGH:      reg_rdata <= 8'(ptr_reg >> 8);
        elmc_pkg::ADDR_LOG_ADDR_LOW:  reg_rdata <= log_addr_low_reg;
        elmc_pkg::ADDR_LOG_ADDR_HIGH: reg_rdata <= log_addr_high_reg;
        elmc_pkg::ADDR_LOG_READ:      reg_rdata <= log_mem[log_sel];
        default:                      reg_rdata <= elmc_pkg::BYTE_ZERO;
      endcase
    end
  end

  // Status outputs from flip-flops
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mission_active <= 1'b0;
      mission_armed  <= 1'b0;
    end else begin
      mission_active <= active_reg;
      mission_armed  <= ctl_reg[elmc_pkg::CTL_ARM];
    end
  end
endmodule // elmc_event_log_mission_control

//--- elmc_event_log_mission_control_bench.sv
// Self-checking bench for the event-log mission controller
`timescale 1ns/100ps
module elmc_event_log_mission_control_bench;
  logic        clock, reset_n, etc_tick, event_in, reg_wr, reg_rd, mission_active, mission_armed;
  logic [63:0] time_date;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [15:0] v;
  logic [15:0] b = 16'h0000;
  int          error_cnt, tests_run, cyc;
  elmc_event_log_mission_control i_dut (.clock(clock), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .etc_tick(etc_tick),
    .time_date(time_date), .event_in(event_in), .mission_active(mission_active), .mission_armed(mission_armed));
  elmc_host_model i_host (.clock(clock), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    i_host.rd(a, b[7:0]);
    chk(b, e);
  endtask
  task automatic ev(input logic lvl);
    @(posedge clock);
    event_in <= lvl;
    repeat (6) @(posedge clock);
    #1;
  endtask
  task automatic ticks(input int n);
    @(posedge clock);
    etc_tick <= 1'b1;
    repeat (n) @(posedge clock);
    etc_tick <= 1'b0;
  endtask
  task automatic clr(input logic [7:0] ctl);
    i_host.wr(8'h0E, ctl | 8'h40);
    i_host.wr(8'h0F, 8'h10);
  endtask
  // Low byte of the address first, then the high byte, then the data port
  task automatic logrd(input int n);
    logic [7:0] lo;
    i_host.wr(8'h41, 8'(2 * n));
    i_host.wr(8'h42, 8'((2 * n) >> 8));
    i_host.rd(8'h43, lo);
    i_host.wr(8'h41, 8'(2 * n + 1));
    i_host.wr(8'h42, 8'((2 * n + 1) >> 8));
    i_host.rd(8'h43, b[7:0]);
    v = {b[7:0], lo};
  endtask
  task automatic t_reset();
    rdc(8'h0F, 16'h0000);
    i_host.wr(8'h0F, 8'h20);
    rdc(8'h0F, 16'h0000);
    i_host.wr(8'h0E, 8'h84);
    rdc(8'h0E, 16'h0004);
  endtask
  task automatic t_trig_none();
    clr(8'h00);
    i_host.wr(8'h0F, 8'h20);
    ev(1'b1);
    ev(1'b0);
    rdc(8'h0F, 16'h0040);
    i_host.wr(8'h0E, 8'h80);
    rdc(8'h0E, 16'h0000);
  endtask
  task automatic t_immediate();
    clr(8'h06);
    rdc(8'h3A, 16'h0000);
    time_date <= 64'h0123456789ABCDEF;
    i_host.wr(8'h0F, 8'h20);
    rdc(8'h0E, 16'h0086);
    rdc(8'h3A, 16'h0000);
    ticks(5);
    ev(1'b1);
    ticks(7);
    ev(1'b0);
    i_host.wr(8'h43, 8'h55);
    rdc(8'h0F, 16'h0000);
    rdc(8'h0E, 16'h0006);
    logrd(0);
    chk(v, 16'h0005);
    logrd(1);
    chk(v, 16'h0007);
    rdc(8'h3A, 16'h0003);
    rdc(8'h3F, 16'h0004);
    rdc(8'h30, 16'h00EF);
    i_host.wr(8'h0F, 8'h20);
    rdc(8'h0F, 16'h0000);
  endtask
  task automatic t_delayed();
    clr(8'h02);
    i_host.wr(8'h0E, 8'h82);
    ev(1'b1);
    chk({15'h0000, mission_active}, 16'h0000);
    chk({15'h0000, mission_armed}, 16'h0001);
    ev(1'b0);
    chk({15'h0000, mission_active}, 16'h0001);
    ticks(2);
    ev(1'b1);
    ev(1'b0);
    i_host.wr(8'h41, 8'h00);
    rdc(8'h3A, 16'h0002);
    rdc(8'h38, 16'h0000);
    logrd(0);
    chk(v, 16'h0002);
  endtask
  task automatic t_rising();
    clr(8'h04);
    i_host.wr(8'h0E, 8'h84);
    ev(1'b1);
    chk({15'h0000, mission_active}, 16'h0001);
    ev(1'b0);
    ev(1'b1);
    i_host.wr(8'h41, 8'h00);
    rdc(8'h3A, 16'h0002);
  endtask
  task automatic t_full(input logic w);
    clr(w ? 8'h0E : 8'h06);
    time_date <= 64'h11;
    i_host.wr(8'h0F, 8'h20);
    repeat (1024) ev(!event_in);
    time_date <= 64'h22;
    ticks(3);
    ev(!event_in);
    i_host.wr(8'h41, 8'h00);
    rdc(8'h3A, 16'h0002);
    rdc(8'h3B, 16'h0004);
    rdc(8'h3F, w ? 16'h0002 : 16'h0000);
    rdc(8'h40, 16'h0000);
    rdc(8'h0F, w ? 16'h0004 : 16'h0000);
    rdc(8'h38, w ? 16'h0003 : 16'h0000);
    rdc(8'h30, w ? 16'h0022 : 16'h0011);
    logrd(0);
    chk(v, w ? 16'h0003 : 16'h0000);
  endtask
  task automatic t_overflow();
    clr(8'h06);
    i_host.wr(8'h0F, 8'h20);
    ticks(65536);
    ev(!event_in);
    i_host.wr(8'h41, 8'h00);
    logrd(0);
    chk(v, 16'hFFFF);
    logrd(1);
    chk(v, 16'h0000);
    rdc(8'h3A, 16'h0002);
  endtask
  initial begin
    reset_n = 1'b0;
    etc_tick = 1'b0;
    event_in = 1'b0;
    time_date = 64'h0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_trig_none();
    t_immediate();
    t_delayed();
    t_rising();
    t_full(1'b0);
    t_full(1'b1);
    t_overflow();
    final_report();
  end
endmodule // elmc_event_log_mission_control_bench

//--- elmc_host_model.sv
// Host model issuing register byte writes and reads
`timescale 1ns/100ps
module elmc_host_model (
  // Clock
  input  wire logic       clock,
  // Register port
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    // Released data no longer shows the last value
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule // elmc_host_model

//--- elmc_pkg.sv
// Package with register map, field positions and sizes of the event-log mission controller
package elmc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL      = 8'h0E;
  localparam logic [7:0] ADDR_STATUS       = 8'h0F;
  localparam logic [7:0] ADDR_STAMP_FIRST  = 8'h30;
  localparam logic [7:0] ADDR_STAMP_LAST   = 8'h37;
  localparam logic [7:0] ADDR_ROLL_LOW     = 8'h38;
  localparam logic [7:0] ADDR_ROLL_HIGH    = 8'h39;
  localparam logic [7:0] ADDR_EVCNT_LOW    = 8'h3A;
  localparam logic [7:0] ADDR_EVCNT_MID    = 8'h3B;
  localparam logic [7:0] ADDR_EVCNT_HIGH   = 8'h3C;
  localparam logic [7:0] ADDR_ETC_LOW      = 8'h3D;
  localparam logic [7:0] ADDR_ETC_HIGH     = 8'h3E;
  localparam logic [7:0] ADDR_PTR_LOW      = 8'h3F;
  localparam logic [7:0] ADDR_PTR_HIGH     = 8'h40;
  localparam logic [7:0] ADDR_LOG_ADDR_LOW = 8'h41;
  localparam logic [7:0] ADDR_LOG_ADDR_HIGH = 8'h42;
  localparam logic [7:0] ADDR_LOG_READ     = 8'h43;
  localparam logic [7:0] ADDR_LOCK_FIRST   = 8'h30;
  // Control register fields
  localparam int CTL_ARM       = 7;
  localparam int CTL_CLR_EN    = 6;
  localparam int CTL_RES_HI    = 5;
  localparam int CTL_RES_LO    = 4;
  localparam int CTL_WRAP_EN   = 3;
  localparam int CTL_TRIG_HIGH = 2;
  localparam int CTL_TRIG_LOW  = 1;
  localparam int CTL_OSC       = 0;
  // Status register fields
  localparam int STS_CLEARED   = 6;
  localparam int STS_ACTIVE    = 5;
  localparam int STS_CLEAR_CMD = 4;
  localparam int STS_WRAP      = 2;
  // Sizes and values
  localparam int LOG_BYTES     = 2048;
  localparam int LOG_RECORDS   = 1024;
  localparam int LOG_ABITS     = 11;
  localparam int STAMP_BYTES   = 8;
  localparam logic [15:0] ETC_MAX   = 16'hFFFF;
  localparam logic [15:0] ETC_ZERO  = 16'h0000;
  localparam logic [23:0] EVCNT_ONE = 24'h000001;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [1:0]  TRIG_NONE = 2'b00;
  localparam logic [7:0]  CTL_RESET = 8'h00;
endpackage
